//--- rtl/rsi_top.sv
/*
 * Status flags, interrupt enable/mask and entry-validity tracking of a
 * real-time clock, with an APB slave for its registers.
 * Assumes the counters, comparators and calendar logic outside drive
 * the event pulses, the counter-invalid level and the entry strobes,
 * all synchronous to pclk.
 */
`timescale 1ns/1ps
`include "rsi_consts.svh"

// Behaviour
// - The corrupt flag reads 0 while the counters have stayed valid since the last status read or clear, and becomes 1 once they go invalid.
// - The corrupt flag keeps reading 1 while the counters are still invalid, whatever was read.
// - Each 1 written to the clear register clears its status flag unless it is set again in the same cycle, and each 0 does nothing.
// - Each 1 written to the enable register turns that source's interrupt on, 0 leaves it.
// - Each 1 written to the disable register turns that source's interrupt off, 0 leaves it.
// - The mask register shows 1 for each enabled and 0 for each disabled source in bits 0 to 4; the corrupt source's enable (bit 5) is not shown.
// - Validity bits 0 and 1 flag bad time and calendar contents since they were last written.
// - Validity bits 2 and 3 flag bad time and calendar alarm contents since last written.
// - Status flags are sticky and hold 1 from their event until they are cleared; the corrupt flag is also dropped by a status read once the counters are valid.
module rsi_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rsi_pkg::rsi_flags_s clock_events,
    input wire rsi_pkg::rsi_valid_s entry_bad,
    input wire rsi_pkg::rsi_valid_s entry_prog,
    output logic irq
);
    import rsi_pkg::*;

    // status, enables and validity
    rsi_flags_s flags_q;
    rsi_flags_s flags_d;
    rsi_flags_s en_q;
    rsi_flags_s en_d;
    rsi_valid_s valid_q;
    rsi_valid_s valid_d;

    // registered read answer
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic err_q;
    logic err_d;

    // bus decode
    logic setup;
    logic wr_acc;
    logic rd_acc;
    logic hit_status;
    logic hit_sccr;
    logic hit_ier;
    logic hit_idr;
    logic hit_imr;
    logic hit_ver;
    logic [`RSI_NFLAG-1:0] clr_bits;
    logic [`RSI_NFLAG-1:0] on_bits;
    logic [`RSI_NFLAG-1:0] off_bits;
    logic [`RSI_NFLAG-1:0] set_bits;
    logic status_read;

    // address match and phase qualifiers
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign hit_status = (paddr == `RSI_ADDR_STATUS);
    assign hit_sccr = (paddr == `RSI_ADDR_STATUS_CLEAR);
    assign hit_ier = (paddr == `RSI_ADDR_IRQ_ENABLE_SET);
    assign hit_idr = (paddr == `RSI_ADDR_IRQ_ENABLE_CLEAR);
    assign hit_imr = (paddr == `RSI_ADDR_IRQ_MASK_VIEW);
    assign hit_ver = (paddr == `RSI_ADDR_ENTRY_VALIDITY);

    // write strobes take effect at the access edge only
    assign clr_bits = (wr_acc & hit_sccr) ? pwdata[`RSI_NFLAG-1:0] : '0;
    assign on_bits = (wr_acc & hit_ier) ? pwdata[`RSI_NFLAG-1:0] : '0;
    assign off_bits = (wr_acc & hit_idr) ? pwdata[`RSI_NFLAG-1:0] : '0;
    assign status_read = rd_acc & hit_status;

    // events and the invalid-counter level all set flags
    assign set_bits = clock_events;

    // no wait states
    assign pready = 1'b1;

    // next status: set wins over clear, corrupt also cleared by a read
    always_comb begin
        flags_d = flags_q & ~clr_bits;
        if (status_read) begin
            flags_d.counter_corrupt_flag = 1'b0;
        end
        flags_d = flags_d | set_bits;
    end

    // next enables
    always_comb begin
        en_d = (en_q & ~off_bits) | on_bits;
    end

    // next validity: a bad entry wins over a fresh write
    always_comb begin
        valid_d = (valid_q & ~entry_prog) | entry_bad;
    end

    // read data and error, prepared in the setup cycle
    always_comb begin
        prdata_d = `RSI_RST_DATA;
        err_d = 1'b0;
        if (setup) begin
            if (hit_status) begin
                prdata_d[`RSI_NFLAG-1:0] = flags_q;
                err_d = pwrite;
            end else if (hit_imr) begin
                prdata_d[`RSI_NMASK-1:0] = en_q[`RSI_NMASK-1:0];
                err_d = pwrite;
            end else if (hit_ver) begin
                prdata_d[`RSI_NVALID-1:0] = valid_q;
                err_d = pwrite;
            end else if (hit_sccr | hit_ier | hit_idr) begin
                err_d = ~pwrite;
            end else begin
                err_d = 1'b1;
            end
        end else begin
            prdata_d = prdata_q;
            err_d = err_q;
        end
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= `RSI_RST_FLAGS;
            en_q <= `RSI_RST_EN;
            valid_q <= `RSI_RST_VALID;
            prdata_q <= `RSI_RST_DATA;
            err_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            en_q <= en_d;
            valid_q <= valid_d;
            prdata_q <= prdata_d;
            err_q <= err_d;
        end
    end

    // bus outputs, error only shown in the access phase
    assign prdata = prdata_q;
    assign pslverr = psel & penable & err_q;

    // one level interrupt from enabled sticky flags
    assign irq = |(flags_q & en_q);

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_corrupt_set;
        clock_events.counter_corrupt_flag |=> flags_q.counter_corrupt_flag;
    endproperty
    a_corrupt_set: assert property (p_corrupt_set)
        else $error("corrupt flag not set by invalid counters");

    property p_corrupt_hold;
        clock_events.counter_corrupt_flag [*3] |=>
            flags_q.counter_corrupt_flag && $past(flags_q.counter_corrupt_flag);
    endproperty
    a_corrupt_hold: assert property (p_corrupt_hold)
        else $error("corrupt flag dropped while counters invalid");

    property p_corrupt_read;
        status_read && !clock_events.counter_corrupt_flag |=>
            !flags_q.counter_corrupt_flag;
    endproperty
    a_corrupt_read: assert property (p_corrupt_read)
        else $error("corrupt flag kept after read of valid counters");

    property p_clear_one;
        wr_acc && hit_sccr && pwdata[`RSI_BIT_SECOND] &&
            !clock_events.second_event |=> !flags_q.second_event;
    endproperty
    a_clear_one: assert property (p_clear_one)
        else $error("second flag not cleared by clear write");

    property p_clear_zero;
        wr_acc && hit_sccr && !pwdata[`RSI_BIT_ALARM] && flags_q.alarm_event
            |=> flags_q.alarm_event;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("alarm flag cleared by zero bit");

    property p_enable;
        wr_acc && hit_ier && pwdata[`RSI_BIT_ACK] |=> en_q.update_ack;
    endproperty
    a_enable: assert property (p_enable)
        else $error("acknowledge interrupt not enabled");

    property p_disable;
        wr_acc && hit_idr && pwdata[`RSI_BIT_TIME] |=> !en_q.time_event;
    endproperty
    a_disable: assert property (p_disable)
        else $error("time event interrupt not disabled");

    property p_enable_zero;
        wr_acc && hit_idr && !pwdata[`RSI_BIT_CAL] |=> $stable(en_q.calendar_event);
    endproperty
    a_enable_zero: assert property (p_enable_zero)
        else $error("calendar enable changed by zero bit");

    property p_mask_read;
        setup && !pwrite && hit_imr |=>
            prdata == {27'h0, $past(en_q[`RSI_NMASK-1:0])};
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask read does not show enables");

    property p_valid_time;
        entry_bad.bad_time_entry |=> valid_q.bad_time_entry;
    endproperty
    a_valid_time: assert property (p_valid_time)
        else $error("bad time entry not flagged");

    property p_valid_calalr;
        entry_prog.bad_calendar_alarm_entry && !entry_bad.bad_calendar_alarm_entry
            |=> !valid_q.bad_calendar_alarm_entry;
    endproperty
    a_valid_calalr: assert property (p_valid_calalr)
        else $error("calendar alarm validity not cleared by write");

    property p_sticky;
        flags_q.alarm_event && !(wr_acc && hit_sccr && pwdata[`RSI_BIT_ALARM])
            |=> flags_q.alarm_event;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("alarm flag lost without clear");

    property p_irq;
        clock_events.second_event && en_q.second_event &&
            !off_bits[`RSI_BIT_SECOND] |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing for enabled event");

    property p_irq_quiet;
        (en_q == '0) |-> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt with all sources disabled");

    // corrupt flag stays low while counters valid
    property p_corrupt_low;
        !flags_q.counter_corrupt_flag && !clock_events.counter_corrupt_flag |=>
            !flags_q.counter_corrupt_flag;
    endproperty
    a_corrupt_low: assert property (p_corrupt_low)
        else $error("corrupt flag set while counters valid");

    // zero bits of an enable write leave the enables alone
    property p_enable_keep;
        wr_acc && hit_ier && !pwdata[`RSI_BIT_ALARM] |=> $stable(en_q.alarm_event);
    endproperty
    a_enable_keep: assert property (p_enable_keep)
        else $error("alarm enable changed by zero bit");

    // remaining validity bits
    property p_valid_cal;
        entry_bad.bad_calendar_entry |=> valid_q.bad_calendar_entry;
    endproperty
    a_valid_cal: assert property (p_valid_cal)
        else $error("bad calendar entry not flagged");

    property p_valid_cal_clear;
        entry_prog.bad_calendar_entry && !entry_bad.bad_calendar_entry
            |=> !valid_q.bad_calendar_entry;
    endproperty
    a_valid_cal_clear: assert property (p_valid_cal_clear)
        else $error("calendar validity not cleared by write");

    property p_valid_time_alarm;
        entry_bad.bad_time_alarm_entry |=> valid_q.bad_time_alarm_entry;
    endproperty
    a_valid_time_alarm: assert property (p_valid_time_alarm)
        else $error("bad time alarm entry not flagged");

    // irq drops once the last enabled flag is cleared and nothing new arrives
    property p_irq_clear;
        irq && wr_acc && hit_sccr && (clock_events == 6'h00) &&
            ((flags_q & en_q & ~pwdata[`RSI_NFLAG-1:0]) == 6'h00) |=> !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("interrupt kept after enabled flags cleared");

    // main scenarios
    c_irq_rise: cover property ($rose(irq));
    c_clear_irq: cover property (irq ##1 (wr_acc && hit_sccr) ##1 !irq);
    c_corrupt_read: cover property (status_read && flags_q.counter_corrupt_flag);
    c_bad_entry: cover property (entry_bad != '0 ##[1:20] (entry_prog != '0));
    c_valid_clear: cover property ((valid_q != '0) ##1 (valid_q == '0));

endmodule

//--- include/rsi_consts.svh
/*
 * Register offsets, field positions, widths and reset values of the
 * status, interrupt and entry-validity block.
 * Assumes 32-bit APB byte addresses and one aligned word per register.
 */
`ifndef RSI_CONSTS_SVH
`define RSI_CONSTS_SVH

// register byte addresses
`define RSI_ADDR_STATUS 32'h400E_1478
`define RSI_ADDR_STATUS_CLEAR 32'h400E_147C
`define RSI_ADDR_IRQ_ENABLE_SET 32'h400E_1480
`define RSI_ADDR_IRQ_ENABLE_CLEAR 32'h400E_1484
`define RSI_ADDR_IRQ_MASK_VIEW 32'h400E_1488
`define RSI_ADDR_ENTRY_VALIDITY 32'h400E_148C

// field layout
`define RSI_NFLAG 6
`define RSI_NMASK 5
`define RSI_NVALID 4
`define RSI_BIT_ACK 0
`define RSI_BIT_ALARM 1
`define RSI_BIT_SECOND 2
`define RSI_BIT_TIME 3
`define RSI_BIT_CAL 4
`define RSI_BIT_ERR 5

// reset values
`define RSI_RST_FLAGS 6'h00
`define RSI_RST_EN 6'h00
`define RSI_RST_VALID 4'h0
`define RSI_RST_DATA 32'h0000_0000

`endif

//--- include/rsi_pkg.sv
/*
 * Types of the status, interrupt and entry-validity block.
 * Assumes nothing of its surroundings.
 */
package rsi_pkg;

    // one bit per clock event, update acknowledge in bit 0
    typedef struct packed {
        logic counter_corrupt_flag;
        logic calendar_event;
        logic time_event;
        logic second_event;
        logic alarm_event;
        logic update_ack;
    } rsi_flags_s;

    // one bit per programmable register, time register in bit 0
    typedef struct packed {
        logic bad_calendar_alarm_entry;
        logic bad_time_alarm_entry;
        logic bad_calendar_entry;
        logic bad_time_entry;
    } rsi_valid_s;

endpackage

//--- test/test_rsi_top.sv
/*
 * Self-checking bench for the status, interrupt and entry-validity block.
 * Assumes a zero-wait APB slave and event inputs synchronous to pclk.
 */
`timescale 1ns/1ps
`include "rsi_consts.svh"
module test_rsi_top;
    import rsi_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, lvl;
    logic [31:0] paddr, pwdata, prdata, rd;
    rsi_flags_s clock_events;
    rsi_valid_s entry_bad, entry_prog;
    logic [5:0] fl, en, v;
    int error_cnt, n_checks, cyc, seed;

    rsi_top rsi_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clock_events(clock_events), .entry_bad(entry_bad),
        .entry_prog(entry_prog), .irq(irq));

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // expected interrupt level from the flag and enable models
    function automatic logic [31:0] irq_exp(input logic [5:0] f, input logic [5:0] e);
        return {31'h0, |(f & e)};
    endfunction

    // one APB transfer, entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0, er}, 32'h0000_0000);
    endtask

    // one-cycle pulses on the event and entry inputs
    task automatic pulse(input logic [5:0] e, input logic [3:0] b, input logic [3:0] p);
        clock_events <= {lvl, e[4:0]};
        entry_bad <= b;
        entry_prog <= p;
        @(posedge pclk);
        clock_events <= {lvl, 5'h00};
        entry_bad <= 4'h0;
        entry_prog <= 4'h0;
        @(posedge pclk);
    endtask

    // main sequence
    initial begin
        seed = 48838;
        {psel, penable, pwrite, lvl} = 4'h0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        clock_events = 6'h00;
        entry_bad = 4'h0;
        entry_prog = 4'h0;
        fl = 6'h00;
        en = 6'h00;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`RSI_ADDR_STATUS, 32'h0000_0000);
        rchk(`RSI_ADDR_IRQ_MASK_VIEW, 32'h0000_0000);
        rchk(`RSI_ADDR_ENTRY_VALIDITY, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        // walk each enable bit on, then off
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `RSI_ADDR_IRQ_ENABLE_SET, 32'h1 << i);
            en[i] = 1'b1;
            rchk(`RSI_ADDR_IRQ_MASK_VIEW, {27'h0, en[4:0]});
        end
        apb(1'b1, `RSI_ADDR_IRQ_ENABLE_SET, 32'h0000_0000);
        rchk(`RSI_ADDR_IRQ_MASK_VIEW, 32'h0000_001F);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `RSI_ADDR_IRQ_ENABLE_CLEAR, 32'h1 << i);
            en[i] = 1'b0;
            rchk(`RSI_ADDR_IRQ_MASK_VIEW, {27'h0, en[4:0]});
        end
        // random enables, events and clears
        for (int n = 0; n < 25; n++) begin
            v = 6'($random(seed));
            apb(1'b1, `RSI_ADDR_IRQ_ENABLE_SET, {26'h0, v});
            en = en | v;
            v = 6'($random(seed));
            apb(1'b1, `RSI_ADDR_IRQ_ENABLE_CLEAR, {26'h0, v});
            en = en & ~v;
            v = 6'($random(seed));
            pulse(v, 4'h0, 4'h0);
            fl = fl | {1'b0, v[4:0]};
            chk({31'h0, irq}, irq_exp(fl, en));
            rchk(`RSI_ADDR_STATUS, {26'h0, fl});
            rchk(`RSI_ADDR_IRQ_MASK_VIEW, {27'h0, en[4:0]});
            v = 6'($random(seed));
            apb(1'b1, `RSI_ADDR_STATUS_CLEAR, {26'h0, v});
            fl = fl & ~v;
            rchk(`RSI_ADDR_STATUS, {26'h0, fl});
            chk({31'h0, irq}, irq_exp(fl, en));
        end
        // corrupt counters: flag stays while still invalid
        apb(1'b1, `RSI_ADDR_IRQ_ENABLE_SET, 32'h0000_0020);
        en[5] = 1'b1;
        lvl = 1'b1;
        pulse(6'h00, 4'h0, 4'h0);
        rchk(`RSI_ADDR_STATUS, {26'h0, fl | 6'h20});
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, `RSI_ADDR_STATUS_CLEAR, 32'h0000_0020);
        rchk(`RSI_ADDR_STATUS, {26'h0, fl | 6'h20});
        // counters valid again: one read still shows the error, the next does not
        lvl = 1'b0;
        pulse(6'h00, 4'h0, 4'h0);
        rchk(`RSI_ADDR_STATUS, {26'h0, fl | 6'h20});
        rchk(`RSI_ADDR_STATUS, {26'h0, fl});
        apb(1'b1, `RSI_ADDR_STATUS_CLEAR, 32'h0000_003F);
        fl = 6'h00;
        rchk(`RSI_ADDR_STATUS, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        // each validity bit set by bad data, cleared by programming
        for (int i = 0; i < 4; i++) begin
            pulse(6'h00, 4'(1 << i), 4'h0);
            rchk(`RSI_ADDR_ENTRY_VALIDITY, 32'h1 << i);
            pulse(6'h00, 4'h0, 4'(1 << i));
            rchk(`RSI_ADDR_ENTRY_VALIDITY, 32'h0000_0000);
        end
        // unmapped read and write to a read-only register
        apb(1'b0, 32'h400E_1490, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b1, `RSI_ADDR_IRQ_MASK_VIEW, 32'h0000_001F);
        chk({31'h0, er}, 32'h0000_0001);
        rchk(`RSI_ADDR_IRQ_MASK_VIEW, {27'h0, en[4:0]});
        // mid-run reset returns enables and flags to zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`RSI_ADDR_IRQ_MASK_VIEW, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        final_report();
    end
endmodule
